// ### src/vic_defs.vh
`ifndef VIC_DEFS_VH
`define VIC_DEFS_VH
// Register selectors on the special-function register port
`define VIC_ADDR_EDGE 2'h0
`define VIC_ADDR_PRI 2'h1
`define VIC_ADDR_SEC 2'h2
// Primary control register fields
`define VIC_PRI_GIE 0
`define VIC_PRI_PINE 1
`define VIC_PRI_FIX2 2
`define VIC_PRI_TMRE 3
`define VIC_PRI_PINF 4
`define VIC_PRI_FIX5 5
`define VIC_PRI_TMRF 6
// Secondary control register fields
`define VIC_SEC_TIMEBASE0_IRQ_ENABLE 0
`define VIC_SEC_TIMEBASE1_IRQ_ENABLE 1
`define VIC_SEC_FIX2 2
`define VIC_SEC_SERE 3
`define VIC_SEC_TIMEBASE0_IRQ_FLAG 4
`define VIC_SEC_TIMEBASE1_IRQ_FLAG 5
`define VIC_SEC_FIX6 6
`define VIC_SEC_SERF 7
// Reset values
`define VIC_RST_EDGE 2'h0
`define VIC_RST_PRI 8'h00
`define VIC_RST_SEC 8'h00
`define VIC_RST_GIE 1'h0
`define VIC_RST_FLAG 1'h0
`define VIC_RST_PRI_EN 2'h0
`define VIC_RST_SEC_EN 3'h0
// Edge select encodings
`define VIC_EDGE_OFF 2'h0
`define VIC_EDGE_RISE 2'h1
`define VIC_EDGE_FALL 2'h2
`define VIC_EDGE_BOTH 2'h3
// Vector addresses, one per source
`define VIC_PC_W 12
`define VIC_VEC_PIN 12'h004
`define VIC_VEC_TMR 12'h008
`define VIC_VEC_TB0 12'h00C
`define VIC_VEC_TB1 12'h010
`define VIC_VEC_SER 12'h014
`endif

// ### src/vic_controller.v
`timescale 1ns/1ps
`include "vic_defs.vh"

// Function
// R1: Event sets its flag regardless of enable; vector taken only when enabled. Here the pin flag sets only while pin enable is set.
// R2: Global enable low blocks every interrupt; flags still latch.
// R3: On interrupt, push next-instruction address then load the source vector.
// R4: Each source has its own distinct vector address.
// R5: Return-from-interrupt pops the saved program counter.
// R6: Servicing an interrupt clears the global enable automatically.
// R7: Requests arriving while disabled stay latched and are serviced later.
// R8: Software setting global enable inside a handler allows nesting.
// R9: No request is acknowledged while the stack is full.
// R10: A flag rising wakes from sleep or idle; already-set flags do not.
// R11: Fixed priority: pin, timer, time base 0, time base 1, serial.
// R12: Pin flag sets on the edge type chosen by the edge select.
// R13: Edge select 00 off, 01 rising, 10 falling, 11 both.
// R14: Pin vector needs global enable, pin enable and non-off edge select.
// R15: Pin acts as interrupt input only when pin enable set and port is input.
// R16: Servicing pin interrupt clears pin flag and global enable.
// R17: Pull-high setting stays in effect in interrupt mode.
// R18: Primary register bit map; reserved bits 5 and 2 unchangeable.
// R19: Secondary register bit map; reserved bits 6 and 2 fixed.
// R20: Edge-control bits 7 to 2 read as zero.
// R21: Return-from-interrupt sets global enable; plain return leaves it.
// R22: Flags stay set until serviced or cleared by software.
// R23: Serial flag sets on byte done, address match or bus time-out.
module vic_controller (
  input wire mclk,
  input wire reset_n,
  input wire [1:0] regAddr,
  input wire regWrite,
  input wire [7:0] regWdata,
  output reg [7:0] regRdata,
  input wire pinIrqIn,
  input wire pinDirInput,
  input wire pinPullHigh,
  output reg pinPullEnable,
  input wire timerOverflow,
  input wire timebase0Tick,
  input wire timebase1Tick,
  input wire serialByteDone,
  input wire serialAddrMatch,
  input wire serialTimeout,
  input wire instrBoundary,
  input wire [`VIC_PC_W-1:0] nextPc,
  input wire stackFull,
  input wire retiExec,
  input wire sleepMode,
  output reg irqTake,
  output reg [`VIC_PC_W-1:0] irqVector,
  output reg [`VIC_PC_W-1:0] irqPushPc,
  output reg wakeUp
);

  reg [1:0] pinSync_reg;
  reg pinLevel_reg;
  reg globalIrqEnable_reg;
  reg [4:0] grant;
  reg [`VIC_PC_W-1:0] vec;
  wire [1:0] pinEdgeSelect;
  wire [1:0] priEnables;
  wire [2:0] secEnables;
  wire pinIrqEnable;
  wire timerIrqEnable;
  wire timebase0IrqEnable;
  wire timebase1IrqEnable;
  wire serialIrqEnable;
  wire [4:0] flags;
  wire [4:0] set;
  wire [4:0] swLoad;
  wire [4:0] swFlag;
  wire pinMode;
  wire rise;
  wire fall;
  wire pinEvent;
  wire [4:0] enables;
  wire [4:0] pending;
  wire take;
  wire wrEdge;
  wire wrPri;
  wire wrSec;

  // Flag index order is also priority order
  localparam PIN = 0;
  localparam TMR = 1;
  localparam TB0 = 2;
  localparam TB1 = 3;
  localparam SER = 4;

  // Pin is asynchronous: two flops before any logic
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pinSync_reg <= 2'h0;
      pinLevel_reg <= 1'b0;
    end else begin
      pinSync_reg <= {pinSync_reg[0], pinIrqIn};
      pinLevel_reg <= pinSync_reg[1];
    end
  end

  assign wrEdge = regWrite & (regAddr == `VIC_ADDR_EDGE);
  assign wrPri = regWrite & (regAddr == `VIC_ADDR_PRI);
  assign wrSec = regWrite & (regAddr == `VIC_ADDR_SEC);

  // Edge select and per-source enables; reserved bits are never stored
  vic_ctrl_bits #(
    .WIDTH(2),
    .RST_VALUE(`VIC_RST_EDGE)
  ) i_edgeSelect (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(wrEdge),
    .value(regWdata[1:0]),
    .bits_reg(pinEdgeSelect)
  );

  vic_ctrl_bits #(
    .WIDTH(2),
    .RST_VALUE(`VIC_RST_PRI_EN)
  ) i_priEnables (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(wrPri), // [R18]
    .value({regWdata[`VIC_PRI_TMRE], regWdata[`VIC_PRI_PINE]}),
    .bits_reg(priEnables)
  );

  vic_ctrl_bits #(
    .WIDTH(3),
    .RST_VALUE(`VIC_RST_SEC_EN)
  ) i_secEnables (
    .mclk(mclk),
    .reset_n(reset_n),
    .load(wrSec), // [R19]
    .value({regWdata[`VIC_SEC_SERE], regWdata[`VIC_SEC_TIMEBASE1_IRQ_ENABLE], regWdata[`VIC_SEC_TIMEBASE0_IRQ_ENABLE]}),
    .bits_reg(secEnables)
  );

  assign pinIrqEnable = priEnables[0];
  assign timerIrqEnable = priEnables[1];
  assign timebase0IrqEnable = secEnables[0];
  assign timebase1IrqEnable = secEnables[1];
  assign serialIrqEnable = secEnables[2];

  assign pinMode = pinIrqEnable & pinDirInput; // [R15]
  assign rise = pinSync_reg[1] & ~pinLevel_reg;
  assign fall = ~pinSync_reg[1] & pinLevel_reg;
  assign pinEvent = pinMode & ( // [R12]
    ((pinEdgeSelect == `VIC_EDGE_RISE) & rise) | // [R13]
    ((pinEdgeSelect == `VIC_EDGE_FALL) & fall) |
    ((pinEdgeSelect == `VIC_EDGE_BOTH) & (rise | fall)));

  assign enables = {serialIrqEnable, timebase1IrqEnable, timebase0IrqEnable,
    timerIrqEnable, pinIrqEnable & (pinEdgeSelect != `VIC_EDGE_OFF)}; // [R14]
  assign pending = flags & enables; // [R1]
  // Taken only at an instruction boundary with room on the stack
  assign take = globalIrqEnable_reg & (|pending) & ~stackFull & instrBoundary; // [R2] [R9]

  // Raw events, one per source
  assign set[PIN] = pinEvent;
  assign set[TMR] = timerOverflow;
  assign set[TB0] = timebase0Tick;
  assign set[TB1] = timebase1Tick;
  assign set[SER] = serialByteDone | serialAddrMatch | serialTimeout; // [R23]

  assign swLoad = {wrSec, wrSec, wrSec, wrPri, wrPri};
  assign swFlag = {regWdata[`VIC_SEC_SERF], regWdata[`VIC_SEC_TIMEBASE1_IRQ_FLAG], regWdata[`VIC_SEC_TIMEBASE0_IRQ_FLAG],
    regWdata[`VIC_PRI_TMRF], regWdata[`VIC_PRI_PINF]};

  // One request flag per source; service clears only the granted one
  vic_flag_cell #(
    .RST_VALUE(`VIC_RST_FLAG)
  ) i_pinFlag (
    .mclk(mclk),
    .reset_n(reset_n),
    .hwSet(set[PIN]),
    .swLoad(swLoad[PIN]),
    .swValue(swFlag[PIN]),
    .serviceClear(take & grant[PIN]), // [R16]
    .flag_reg(flags[PIN])
  );

  vic_flag_cell #(
    .RST_VALUE(`VIC_RST_FLAG)
  ) i_timerFlag (
    .mclk(mclk),
    .reset_n(reset_n),
    .hwSet(set[TMR]),
    .swLoad(swLoad[TMR]),
    .swValue(swFlag[TMR]),
    .serviceClear(take & grant[TMR]),
    .flag_reg(flags[TMR])
  );

  vic_flag_cell #(
    .RST_VALUE(`VIC_RST_FLAG)
  ) i_timebase0Flag (
    .mclk(mclk),
    .reset_n(reset_n),
    .hwSet(set[TB0]),
    .swLoad(swLoad[TB0]),
    .swValue(swFlag[TB0]),
    .serviceClear(take & grant[TB0]),
    .flag_reg(flags[TB0])
  );

  vic_flag_cell #(
    .RST_VALUE(`VIC_RST_FLAG)
  ) i_timebase1Flag (
    .mclk(mclk),
    .reset_n(reset_n),
    .hwSet(set[TB1]),
    .swLoad(swLoad[TB1]),
    .swValue(swFlag[TB1]),
    .serviceClear(take & grant[TB1]),
    .flag_reg(flags[TB1])
  );

  vic_flag_cell #(
    .RST_VALUE(`VIC_RST_FLAG)
  ) i_serialFlag (
    .mclk(mclk),
    .reset_n(reset_n),
    .hwSet(set[SER]),
    .swLoad(swLoad[SER]),
    .swValue(swFlag[SER]),
    .serviceClear(take & grant[SER]),
    .flag_reg(flags[SER])
  );

  always @* begin
    grant = 5'h00;
    vec = `VIC_VEC_PIN;
    if (pending[PIN]) begin // [R11]
      grant[PIN] = 1'b1;
      vec = `VIC_VEC_PIN; // [R4]
    end else if (pending[TMR]) begin
      grant[TMR] = 1'b1;
      vec = `VIC_VEC_TMR;
    end else if (pending[TB0]) begin
      grant[TB0] = 1'b1;
      vec = `VIC_VEC_TB0;
    end else if (pending[TB1]) begin
      grant[TB1] = 1'b1;
      vec = `VIC_VEC_TB1;
    end else if (pending[SER]) begin
      grant[SER] = 1'b1;
      vec = `VIC_VEC_SER;
    end
  end

  // Service clears, return-from-interrupt sets, software write otherwise
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      globalIrqEnable_reg <= `VIC_RST_GIE;
    end else if (take) begin
      globalIrqEnable_reg <= 1'b0; // [R6] [R16]
    end else if (retiExec) begin
      // The stack pop itself is the core's; only the enable returns here
      globalIrqEnable_reg <= 1'b1; // [R5] [R21] [R7]
    end else if (wrPri) begin
      globalIrqEnable_reg <= regWdata[`VIC_PRI_GIE]; // [R8]
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      irqTake <= 1'b0;
      irqVector <= `VIC_VEC_PIN;
      irqPushPc <= {`VIC_PC_W{1'b0}};
      wakeUp <= 1'b0;
      pinPullEnable <= 1'b0;
    end else begin
      irqTake <= take; // [R3]
      if (take) begin
        irqVector <= vec; // [R3]
        irqPushPc <= nextPc; // [R3]
      end
      // Only a rising flag wakes; enables play no part except pin enable, which gates the pin event
      wakeUp <= sleepMode & (|(set & ~flags)); // [R10]
      pinPullEnable <= pinPullHigh; // [R17]
    end
  end

  // Reserved bits read their fixed zero value
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 8'h00;
    end else begin
      case (regAddr)
        `VIC_ADDR_EDGE: regRdata <= {6'h00, pinEdgeSelect}; // [R20]
        `VIC_ADDR_PRI: regRdata <= {1'b0, flags[TMR], 1'b0, flags[PIN],
          timerIrqEnable, 1'b0, pinIrqEnable, globalIrqEnable_reg}; // [R18]
        `VIC_ADDR_SEC: regRdata <= {flags[SER], 1'b0, flags[TB1], flags[TB0],
          serialIrqEnable, 1'b0, timebase1IrqEnable,
          timebase0IrqEnable}; // [R19]
        default: regRdata <= 8'h00;
      endcase
    end
  end

endmodule // vic_controller

module vic_ctrl_bits #(
  parameter WIDTH = 1,
  parameter [WIDTH-1:0] RST_VALUE = {WIDTH{1'b0}}
) (
  input wire mclk,
  input wire reset_n,
  input wire load,
  input wire [WIDTH-1:0] value,
  output reg [WIDTH-1:0] bits_reg
);

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      bits_reg <= RST_VALUE;
    end else if (load) begin
      bits_reg <= value;
    end
  end

endmodule // vic_ctrl_bits

module vic_flag_cell #(
  parameter [0:0] RST_VALUE = 1'b0
) (
  input wire mclk,
  input wire reset_n,
  input wire hwSet,
  input wire swLoad,
  input wire swValue,
  input wire serviceClear,
  output reg flag_reg
);

  reg flag_next;

  always @* begin
    flag_next = flag_reg;
    if (swLoad) begin // [R22]
      flag_next = swValue;
    end
    if (serviceClear) begin
      flag_next = 1'b0; // [R16]
    end
    // Hardware set wins over any clear in the same cycle
    if (hwSet) begin
      flag_next = 1'b1; // [R1] [R7]
    end
  end

  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      flag_reg <= RST_VALUE;
    end else begin
      flag_reg <= flag_next;
    end
  end

endmodule // vic_flag_cell

// ### bench/vic_controller_monitor.sv
`timescale 1ns/1ps
`include "vic_defs.vh"
module vic_controller_monitor (
  input logic mclk,
  input logic reset_n,
  input logic regWrite,
  input logic retiExec,
  input logic instrBoundary,
  input logic stackFull,
  input logic sleepMode,
  input logic pinPullHigh,
  input logic pinPullEnable,
  input logic [11:0] nextPc,
  input logic irqTake,
  input logic [11:0] irqVector,
  input logic [11:0] irqPushPc,
  input logic wakeUp
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_idle;
    !retiExec && !regWrite;
  endsequence
  sequence s_take_idle;
    irqTake ##0 s_idle [*3];
  endsequence
  a_take_single: assert property (irqTake |=> !irqTake)
    else $error("take on two cycles in a row");
  a_stays_off: assert property (s_take_idle |=> !irqTake)
    else $error("take while global enable clear");
  a_full_blocks: assert property (irqTake |-> !$past(stackFull))
    else $error("take with stack full");
  a_at_boundary: assert property (irqTake |-> $past(instrBoundary))
    else $error("take off a boundary");
  a_push_next: assert property (irqTake |-> irqPushPc == $past(nextPc))
    else $error("wrong pushed address");
  a_vector_known: assert property (
    irqTake |-> irqVector inside {`VIC_VEC_PIN, `VIC_VEC_TMR, `VIC_VEC_TB0, `VIC_VEC_TB1,
    `VIC_VEC_SER}) else $error("unknown vector");
  a_wake_sleep: assert property (wakeUp |-> $past(sleepMode))
    else $error("wake outside sleep");
  a_pull_follows: assert property (
    $past(reset_n) |-> pinPullEnable == $past(pinPullHigh)) else $error("pull lost");
endmodule // vic_controller_monitor
bind vic_controller vic_controller_monitor i_mon (.mclk, .reset_n, .regWrite, .retiExec,
  .instrBoundary, .stackFull, .sleepMode, .pinPullHigh, .pinPullEnable, .nextPc, .irqTake,
  .irqVector, .irqPushPc, .wakeUp);

// ### bench/vic_core_model.sv
`timescale 1ns/1ps
module vic_core_model #(parameter int DEPTH = 2) (
  input logic mclk,
  input logic reset_n,
  input logic irqTake,
  input logic retiExec,
  input logic [11:0] irqVector,
  output logic instrBoundary,
  output logic stackFull,
  output logic [11:0] nextPc
);
  int depth;
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      depth <= 0;
      nextPc <= 12'h100;
    end else begin
      // Push on take, pop on return; fetch resumes from the vector
      depth <= depth + int'(irqTake) - int'(retiExec && depth > 0);
      nextPc <= irqTake ? irqVector + 12'h001 : nextPc + 12'h001;
    end
  end
  assign stackFull = (depth >= DEPTH);
  // Two-cycle instructions: a boundary every other fetch
  assign instrBoundary = !nextPc[0];
endmodule // vic_core_model

// ### bench/tb_vectored_interrupt_control.sv
`timescale 1ns/1ps
`include "vic_defs.vh"
module tb_vectored_interrupt_control;
  typedef struct {int src; int edg; int lvl; int take; logic [11:0] vec;} vic_row_t;
  logic mclk = 1'h0, reset_n = 1'h0, regWrite = 1'h0, pinIrqIn = 1'h0, pinDirInput = 1'h1;
  logic pinPullHigh = 1'h0, retiExec = 1'h0, sleepMode = 1'h0, irqTake, wakeUp;
  logic instrBoundary, stackFull, pinPullEnable;
  logic [1:0] regAddr = 2'h0;
  logic [7:0] regWdata = 8'h00, regRdata;
  logic [5:0] ev = 6'h00;
  logic [11:0] nextPc, irqVector, irqPushPc;
  int fails = 0, compares = 0, wakes = 0, takes = 0, mark = 0, w;
  vic_row_t rows[12] = '{'{0, 1, 1, 1, `VIC_VEC_PIN}, '{0, 2, 0, 1, `VIC_VEC_PIN},
    '{0, 3, 1, 1, `VIC_VEC_PIN}, '{0, 3, 0, 1, `VIC_VEC_PIN}, '{0, 0, 1, 0, 12'h000},
    '{0, 1, 0, 0, 12'h000}, '{1, 0, 0, 1, `VIC_VEC_TMR}, '{2, 0, 0, 1, `VIC_VEC_TB0},
    '{3, 0, 0, 1, `VIC_VEC_TB1}, '{4, 0, 0, 1, `VIC_VEC_SER}, '{5, 0, 0, 1, `VIC_VEC_SER},
    '{6, 0, 0, 1, `VIC_VEC_SER}};
  vic_controller i_dut (.mclk, .reset_n, .regAddr, .regWrite, .regWdata, .regRdata, .pinIrqIn,
    .pinDirInput, .pinPullHigh, .pinPullEnable, .timerOverflow(ev[0]), .timebase0Tick(ev[1]),
    .timebase1Tick(ev[2]), .serialByteDone(ev[3]), .serialAddrMatch(ev[4]),
    .serialTimeout(ev[5]), .instrBoundary, .nextPc, .stackFull, .retiExec, .sleepMode,
    .irqTake, .irqVector, .irqPushPc, .wakeUp);
  vic_core_model i_core (.mclk, .reset_n, .irqTake, .retiExec, .irqVector, .instrBoundary,
    .stackFull, .nextPc);
  initial forever #12.5 mclk = ~mclk;
  always @(posedge mclk) if (wakeUp === 1'h1) wakes++;
  always @(posedge mclk) if (irqTake === 1'h1) takes++;
  task automatic end_sim;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(string what, logic [11:0] exp, logic [11:0] got);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [1:0] a, logic [7:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'h1;
    @(posedge mclk);
    regWrite <= 1'h0;
    @(posedge mclk);
  endtask
  task automatic rd(logic [1:0] a, logic [7:0] e);
    regAddr <= a;
    @(posedge mclk);
    #1 chk("rdata", {4'h0, e}, {4'h0, regRdata});
  endtask
  task automatic fire(int src, int lvl);
    if (src == 0) pinIrqIn <= 1'(lvl);
    else ev[src-1] <= 1'h1;
    @(posedge mclk);
    ev <= 6'h00;
  endtask
  task automatic ret;
    retiExec <= 1'h1;
    @(posedge mclk);
    retiExec <= 1'h0;
  endtask
  task automatic waitTake(int e, logic [11:0] v);
    int n = 0;
    while (takes == mark && n < 16) begin
      @(posedge mclk);
      #1 n++;
    end
    chk("take", 12'(e), 12'(takes - mark));
    if (e != 0) chk("vector", v, irqVector);
    if (e != 0 && takes == mark) end_sim;
    mark = takes;
  endtask
  initial begin
    repeat (3) @(posedge mclk);
    reset_n <= 1'h1;
    @(posedge mclk);
    foreach (rows[i]) begin
      wr(`VIC_ADDR_EDGE, {6'h00, rows[i].edg[1:0]});
      wr(`VIC_ADDR_SEC, 8'h0B);
      wr(`VIC_ADDR_PRI, 8'h0B);
      fire(rows[i].src, rows[i].lvl);
      waitTake(rows[i].take, rows[i].vec);
      if (rows[i].take != 0) ret;
    end
    wr(`VIC_ADDR_SEC, 8'h08);
    wr(`VIC_ADDR_PRI, 8'h08);
    ev <= 6'h09;
    @(posedge mclk);
    ev <= 6'h00;
    waitTake(0, 12'h000);
    wr(`VIC_ADDR_PRI, 8'h49);
    waitTake(1, `VIC_VEC_TMR);
    rd(`VIC_ADDR_PRI, 8'h08);
    ret;
    waitTake(1, `VIC_VEC_SER);
    wr(`VIC_ADDR_SEC, 8'h03);
    wr(`VIC_ADDR_PRI, 8'h01);
    fire(2, 0);
    waitTake(1, `VIC_VEC_TB0);
    wr(`VIC_ADDR_PRI, 8'h01);
    fire(3, 0);
    waitTake(0, 12'h000);
    ret;
    waitTake(1, `VIC_VEC_TB1);
    wr(`VIC_ADDR_SEC, 8'h00);
    sleepMode <= 1'h1;
    w = wakes;
    fire(2, 0);
    repeat (3) @(posedge mclk);
    fire(2, 0);
    repeat (3) @(posedge mclk);
    chk("wakes", 12'h001, 12'(wakes - w));
    rd(`VIC_ADDR_SEC, 8'h10);
    pinDirInput <= 1'h0;
    pinPullHigh <= 1'h1;
    wr(`VIC_ADDR_EDGE, 8'h03);
    wr(`VIC_ADDR_PRI, 8'h03);
    fire(0, 1);
    repeat (3) @(posedge mclk);
    rd(`VIC_ADDR_PRI, 8'h03);
    chk("pull", 12'h001, {11'h000, pinPullEnable});
    reset_n <= 1'h0;
    @(posedge mclk);
    reset_n <= 1'h1;
    for (int a = 0; a < 4; a++) rd(a[1:0], 8'h00);
    wr(`VIC_ADDR_EDGE, 8'hFF);
    wr(`VIC_ADDR_PRI, 8'hFE);
    wr(`VIC_ADDR_SEC, 8'hFF);
    wr(2'h3, 8'hFF);
    rd(`VIC_ADDR_EDGE, 8'h03);
    rd(`VIC_ADDR_PRI, 8'h5A);
    rd(`VIC_ADDR_SEC, 8'hBB);
    rd(2'h3, 8'h00);
    end_sim;
  end
endmodule // tb_vectored_interrupt_control
